//--- dwell_timer.sv
/*
  Dwell timer: counts a millisecond interval down using a cycle prescaler.
  Assumes load is a one-cycle pulse; done pulses one cycle when the interval ends.
*/
`timescale 1ns/1ps
module dwell_timer #(
  parameter int unsigned CYC_PER_MS = scan_pkg::CYCLES_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        load,
  input  wire logic        enable,
  input  wire logic [19:0] ms_value,
  output      logic        done
);

  initial begin
    if (CYC_PER_MS < 1 || CYC_PER_MS > 65535) $error("CYC_PER_MS out of range");
  end

  logic [15:0] pre_reg;
  logic [19:0] ms_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_reg <= 16'h0000;
      ms_reg  <= 20'h00000;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        pre_reg <= 16'(CYC_PER_MS - 1);
        ms_reg  <= (ms_value == 20'h00000) ? 20'h00001 : ms_value;
      end else if (enable && ms_reg != 20'h00000) begin
        if (pre_reg == 16'h0000) begin
          pre_reg <= 16'(CYC_PER_MS - 1);
          ms_reg  <= ms_reg - 20'h00001;
          if (ms_reg == 20'h00001) done <= 1'b1;
        end else begin
          pre_reg <= pre_reg - 16'h0001;
        end
      end
    end
  end

endmodule : dwell_timer

//--- keypad_model.sv
/*
  Operator keypad model: issues one-cycle key events.
  Assumes the sequencer samples key on the rising edge of clk.
*/
`timescale 1ns/1ps
module keypad_model (
  input  wire logic     clk,
  output scan_pkg::key_s key
);
  initial key = '0;
  task automatic press(input scan_pkg::key_e c, input logic [3:0] d);
    @(posedge clk);
    key <= '{valid: 1'b1, code: c, digit: d};
    @(posedge clk);
    // Idle digit is scrambled so nothing can lean on a stale value
    key <= '{valid: 1'b0, code: c, digit: ~d};
  endtask : press
endmodule : keypad_model

//--- relay_scan_asserts.sv
/*
  Port checker for the relay scan sequencer, bound to its top module.
  Assumes one-cycle key events, one key per cycle, and a single clock domain.
*/
`timescale 1ns/1ps
module relay_scan_asserts #(
  parameter int unsigned MSG_CYCLES = 10,
  parameter int unsigned CYC_PER_MS = 2
) (
  input wire logic             clk,
  input wire logic             rst_b,
  input wire scan_pkg::key_s   key,
  input wire logic [2:0]       units_chained,
  input wire logic [6:0]       relay_channel,
  input wire logic             relay_close,
  input wire logic [2:0]       pole_count,
  input wire scan_pkg::lamps_s lamps,
  input wire logic [6:0]       begin_channel,
  input wire logic [6:0]       end_channel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic ss;
  logic rk;
  assign ss = key.valid && key.code == scan_pkg::KEY_START_HALT;
  assign rk = key.valid && key.code == scan_pkg::KEY_RESET;

  AST_HALT: assert property (ss && lamps.run |=> !lamps.run && relay_close
    && $stable(relay_channel)) else $error("halt did not hold the channel");
  AST_RESUME: assert property (ss && !lamps.run && relay_close |=> lamps.run
    && relay_close && relay_channel == $past(relay_channel))
    else $error("resume moved the channel");
  AST_START: assert property (ss && !lamps.run && !relay_close
    |=> lamps.run && relay_close && relay_channel == $past(begin_channel))
    else $error("start did not begin at the begin channel");
  AST_RESET: assert property (rk |=> relay_channel == begin_channel
    && !relay_close && !lamps.run) else $error("reset key did not return to begin");
  AST_VIEW: assert property (key.valid && key.code == scan_pkg::KEY_CHANNEL
    |=> lamps.channel_view) else $error("channel view lamp not lit");
  AST_REPEAT: assert property (key.valid && key.code == scan_pkg::KEY_REPEAT
    |=> lamps.repeat_pass && !lamps.one_pass) else $error("repeat mode not selected");
  AST_ONE: assert property (key.valid && key.code == scan_pkg::KEY_ONE_PASS
    |=> lamps.one_pass && !lamps.repeat_pass) else $error("one-pass mode not selected");
  AST_STEP: assert property (lamps.run && !key.valid && relay_channel != end_channel
    |=> $stable(relay_channel) || relay_channel == $past(relay_channel) + 7'h01)
    else $error("scan skipped a channel");
  AST_WRAP: assert property (lamps.run && !key.valid && relay_channel == end_channel
    |=> $stable(relay_channel) || relay_channel == begin_channel)
    else $error("scan ran past the end channel");
  AST_PASS_END: assert property ($fell(lamps.run) && !$past(key.valid)
    |-> !relay_close && relay_channel == begin_channel) else $error("pass end wrong");
  AST_MSG: assert property ($rose(lamps.no_channel) |=> lamps.no_channel[*8])
    else $error("no-channel message too short");
  AST_POLES: assert property (pole_count inside {3'h1, 3'h2, 3'h4})
    else $error("illegal pole count");
endmodule : relay_scan_asserts

bind relay_scan_sequencer relay_scan_asserts #(.MSG_CYCLES(MSG_CYCLES), .CYC_PER_MS(CYC_PER_MS))
  u_chk (.clk(clk), .rst_b(rst_b), .key(key), .units_chained(units_chained),
  .relay_channel(relay_channel), .relay_close(relay_close), .pole_count(pole_count),
  .lamps(lamps), .begin_channel(begin_channel), .end_channel(end_channel));

//--- relay_scan_sequencer.sv
/*
  Front-panel channel scan sequencer: key entry, scan control, relay and lamp drive.
  Assumes key events are one-cycle synchronous pulses, one key per cycle.
  // Summary of operation
  // (RULE1) Start closes begin channel, lamp on, advance
  // (RULE2) Repeat mode wraps end back to begin
  // (RULE3) Start/halt while scanning halts, channel stays closed
  // (RULE4) Start/halt while halted resumes from current channel
  // (RULE5) Reset key stops scan, returns to begin
  // (RULE6) Unavailable end channel shows message half second
  // (RULE7) Channel then reset: lamp, view, begin
  // (RULE8) Repeat key selects repeating mode, lamp
  // (RULE9) One-pass key selects one-pass mode, lamp
  // (RULE10) One-pass scans begin to end once, stops
  // (RULE11) Two digits then begin/end key set limits
  // (RULE12) After reset, start begins at begin channel
  // (RULE13) Dwell key, digits, enter program interval
  // (RULE14) Program setting six selects 1/2/4 poles
  // (RULE15) Chained units extend range to 100 channels
  // (RULE16) Dwell held as six BCD digits, milliseconds
*/
`timescale 1ns/1ps
module relay_scan_sequencer #(
  parameter int unsigned MSG_CYCLES = scan_pkg::MSG_CYCLES,
  parameter int unsigned CYC_PER_MS = scan_pkg::CYCLES_PER_MS
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire scan_pkg::key_s  key,
  input  wire logic [2:0]      units_chained,
  output      logic [6:0]      relay_channel,
  output      logic            relay_close,
  output      logic [2:0]      pole_count,
  output      scan_pkg::lamps_s lamps,
  output      logic [6:0]      begin_channel,
  output      logic [6:0]      end_channel
);

  initial begin
    if (MSG_CYCLES < 1 || MSG_CYCLES > 16777215) $error("MSG_CYCLES out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_DWELL, ST_HALT} state_e;
  typedef enum logic [1:0] {EN_NONE, EN_DWELL, EN_PROGRAM} entry_e;

  function automatic logic [6:0] bcd2_to_bin(input logic [7:0] b);
    // Widen the tens digit first: a 4-bit product would wrap above 15
    bcd2_to_bin = 7'(b[7:4]) * 7'd10 + 7'(b[3:0]);
  endfunction : bcd2_to_bin

  function automatic logic [19:0] bcd6_to_ms(input logic [23:0] b);
    logic [19:0] acc;
    acc = 20'h00000;
    for (int i = 5; i >= 0; i--) begin
      acc = 20'(acc * 20'd10) + 20'(b[i*4 +: 4]);
    end
    bcd6_to_ms = acc;
  endfunction : bcd6_to_ms

  state_e      state_reg;
  entry_e      entry_reg;
  logic [23:0] digits_reg;
  logic [23:0] dwell_bcd_reg;
  logic [19:0] dwell_ms_reg;
  logic        chan_prefix_reg;
  logic        prog6_reg;
  logic [23:0] msg_cnt_reg;
  logic        timer_load;
  logic        timer_done;
  logic [6:0]  avail_max;
  logic [6:0]  entered_chan;
  logic        key_start;
  logic        key_reset;
  logic        run_reg;
  logic        view_reg;
  logic        one_pass_reg;
  logic        repeat_reg;
  logic        no_chan_reg;

  // Each lamp is its own flop so that every lamp has exactly one writing process
  assign lamps = '{run: run_reg, channel_view: view_reg, one_pass: one_pass_reg,
                   repeat_pass: repeat_reg, no_channel: no_chan_reg};

  assign avail_max    = 7'(scan_pkg::UNIT_CHANNELS) * 7'(units_chained == 3'h0 ? 3'h1 :
                        (units_chained > 3'(scan_pkg::MAX_UNITS) ? 3'(scan_pkg::MAX_UNITS)
                        : units_chained)); // RULE15
  assign entered_chan = bcd2_to_bin(digits_reg[7:0]);
  assign key_start    = key.valid && key.code == scan_pkg::KEY_START_HALT;
  assign key_reset    = key.valid && key.code == scan_pkg::KEY_RESET;
  assign timer_load   = (key_start && state_reg != ST_DWELL) ||
                        (timer_done && state_reg == ST_DWELL);

  dwell_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (timer_load),
    .enable   (state_reg == ST_DWELL),
    .ms_value (dwell_ms_reg),
    .done     (timer_done)
  );

  // Digit shift register shared by channel, dwell and program entry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      digits_reg <= 24'h000000;
      entry_reg  <= EN_NONE;
    end else if (key.valid) begin
      case (key.code)
        scan_pkg::KEY_DIGIT:   digits_reg <= {digits_reg[19:0], key.digit}; // RULE11
        scan_pkg::KEY_DWELL: begin
          entry_reg  <= EN_DWELL; // RULE13
          digits_reg <= 24'h000000;
        end
        scan_pkg::KEY_PROGRAM: begin
          entry_reg  <= EN_PROGRAM;
          digits_reg <= 24'h000000;
        end
        default: begin
          entry_reg  <= EN_NONE;
          digits_reg <= 24'h000000;
        end
      endcase
    end
  end

  // Dwell interval, BCD milliseconds, converted into a register every cycle so the timer load is cheap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dwell_bcd_reg <= scan_pkg::RESET_DWELL;
      dwell_ms_reg  <= 20'h00000;
    end else begin
      dwell_ms_reg <= bcd6_to_ms(dwell_bcd_reg); // RULE16
      if (key.valid && key.code == scan_pkg::KEY_ENTER && entry_reg == EN_DWELL)
        dwell_bcd_reg <= digits_reg; // RULE13
    end
  end

  // Pole configuration, program setting 6 then value then enter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pole_count <= scan_pkg::RESET_POLES;
      prog6_reg  <= 1'b0;
    end else if (key.valid) begin
      if (key.code == scan_pkg::KEY_DIGIT && entry_reg == EN_PROGRAM && !prog6_reg)
        prog6_reg <= (key.digit == 4'(scan_pkg::POLE_SETTING)); // RULE14
      else if (key.code != scan_pkg::KEY_DIGIT)
        prog6_reg <= 1'b0;
      if (key.code == scan_pkg::KEY_ENTER && prog6_reg &&
          (digits_reg[3:0] == 4'h1 || digits_reg[3:0] == 4'h2 || digits_reg[3:0] == 4'h4))
        pole_count <= digits_reg[2:0]; // RULE14
    end
  end

  // Channel limits; an unavailable end channel is refused and flagged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      begin_channel <= scan_pkg::RESET_BEGIN[6:0];
      end_channel   <= scan_pkg::RESET_END[6:0];
      msg_cnt_reg   <= 24'h000000;
    end else begin
      if (msg_cnt_reg != 24'h000000) msg_cnt_reg <= msg_cnt_reg - 24'h000001;
      if (key.valid && key.code == scan_pkg::KEY_BEGIN && entered_chan != 7'h00 &&
          entered_chan <= avail_max)
        begin_channel <= entered_chan; // RULE11
      if (key.valid && key.code == scan_pkg::KEY_END) begin
        if (entered_chan == 7'h00 || entered_chan > avail_max)
          msg_cnt_reg <= 24'(MSG_CYCLES); // RULE6
        else
          end_channel <= entered_chan; // RULE11
      end
    end
  end

  // Scan mode selection, mode lamps and the no-channel lamp
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      one_pass_reg <= 1'b1;
      repeat_reg   <= 1'b0;
      no_chan_reg  <= 1'b0;
    end else begin
      no_chan_reg <= msg_cnt_reg != 24'h000000; // RULE6
      if (key.valid && key.code == scan_pkg::KEY_REPEAT) begin
        repeat_reg   <= 1'b1; // RULE8
        one_pass_reg <= 1'b0;
      end else if (key.valid && key.code == scan_pkg::KEY_ONE_PASS) begin
        one_pass_reg <= 1'b1; // RULE9
        repeat_reg   <= 1'b0;
      end
    end
  end

  // Channel view lamp, armed by the channel key
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_prefix_reg <= 1'b0;
      view_reg        <= 1'b0;
    end else if (key.valid) begin
      chan_prefix_reg <= key.code == scan_pkg::KEY_CHANNEL;
      if (key.code == scan_pkg::KEY_CHANNEL || (key_reset && chan_prefix_reg))
        view_reg <= 1'b1; // RULE7
    end
  end

  // Sequencer: reset wins over start/halt pressed in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_IDLE;
      relay_channel <= scan_pkg::RESET_BEGIN[6:0];
      relay_close   <= 1'b0;
      run_reg       <= 1'b0;
    end else if (key_reset) begin
      state_reg     <= ST_IDLE; // RULE5 RULE7
      relay_channel <= begin_channel;
      relay_close   <= 1'b0;
      run_reg       <= 1'b0;
    end else begin
      case (state_reg)
        // Begin limit may have been reprogrammed while idle, so reload it here
        ST_IDLE: if (key_start) begin
          state_reg     <= ST_DWELL; // RULE12 RULE1
          relay_channel <= begin_channel;
          relay_close   <= 1'b1;
          run_reg       <= 1'b1;
        end
        ST_HALT: if (key_start) begin
          state_reg   <= ST_DWELL; // RULE4
          relay_close <= 1'b1;
          run_reg     <= 1'b1;
        end
        ST_DWELL: begin
          if (key_start) begin
            state_reg <= ST_HALT; // RULE3
            run_reg   <= 1'b0;
          end else if (timer_done) begin
            if (relay_channel >= end_channel) begin
              relay_channel <= begin_channel;
              if (one_pass_reg) begin
                state_reg   <= ST_IDLE; // RULE10
                relay_close <= 1'b0;
                run_reg     <= 1'b0;
              end // RULE2
            end else begin
              relay_channel <= relay_channel + 7'h01; // RULE1
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule : relay_scan_sequencer

//--- relay_scan_sequencer_tb_top.sv
/*
  Self-checking bench for the relay scan sequencer with shortened timing.
  Assumes the keypad model and the bound port checker are compiled alongside.
*/
`timescale 1ns/1ps
module relay_scan_sequencer_tb_top;
  logic             clk;
  logic             rst_b;
  logic [2:0]       units_chained;
  scan_pkg::key_s   key;
  logic [6:0]       relay_channel;
  logic [6:0]       begin_channel;
  logic [6:0]       end_channel;
  logic             relay_close;
  logic [2:0]       pole_count;
  scan_pkg::lamps_s lamps;
  int               n_fail;
  int               samples_checked;
  int               cycles;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  relay_scan_sequencer #(.MSG_CYCLES(10), .CYC_PER_MS(2)) dut (.clk(clk), .rst_b(rst_b),
    .key(key), .units_chained(units_chained), .relay_channel(relay_channel),
    .relay_close(relay_close), .pole_count(pole_count), .lamps(lamps),
    .begin_channel(begin_channel), .end_channel(end_channel));
  keypad_model kp (.clk(clk), .key(key));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic k(input scan_pkg::key_e c, input logic [3:0] d = 4'h0);
    kp.press(c, d);
  endtask : k

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic chan(input logic [3:0] t, input logic [3:0] u, input scan_pkg::key_e c);
    k(scan_pkg::KEY_DIGIT, t);
    k(scan_pkg::KEY_DIGIT, u);
    k(c);
    settle;
  endtask : chan

  task automatic t_setup;
    chan(4'h0, 4'h3, scan_pkg::KEY_BEGIN);
    check(8'(begin_channel), 8'h03);
    @(posedge clk) units_chained <= 3'h0;
    chan(4'h6, 4'h0, scan_pkg::KEY_END);
    check(8'({lamps.no_channel, end_channel}), 8'h81);
    @(posedge clk) units_chained <= 3'h3;
    chan(4'h6, 4'h0, scan_pkg::KEY_END);
    check(8'(end_channel), 8'h3c);
    chan(4'h0, 4'h5, scan_pkg::KEY_END);
    check(8'(end_channel), 8'h05);
    k(scan_pkg::KEY_PROGRAM);
    chan(4'h6, 4'h4, scan_pkg::KEY_ENTER);
    k(scan_pkg::KEY_PROGRAM);
    chan(4'h6, 4'h3, scan_pkg::KEY_ENTER);
    check(8'(pole_count), 8'h04);
    k(scan_pkg::KEY_DWELL);
    repeat (4) k(scan_pkg::KEY_DIGIT, 4'h0);
    chan(4'h0, 4'h2, scan_pkg::KEY_ENTER);
  endtask : t_setup

  task automatic t_single;
    logic [6:0] prev;
    logic [7:0] exp;
    int         cnt;
    k(scan_pkg::KEY_CHANNEL);
    k(scan_pkg::KEY_RESET);
    k(scan_pkg::KEY_REPEAT);
    k(scan_pkg::KEY_ONE_PASS);
    settle;
    check(8'({lamps.channel_view, relay_channel}), 8'h83);
    check(8'({lamps.one_pass, lamps.repeat_pass}), 8'h02);
    k(scan_pkg::KEY_START_HALT);
    @(posedge clk);
    #1;
    check(8'({lamps.run, relay_close, relay_channel[5:0]}), 8'hc3);
    prev = relay_channel;
    exp = 8'h04;
    cnt = 0;
    while (lamps.run === 1'b1) begin
      @(posedge clk);
      #1;
      cnt++;
      if (lamps.run === 1'b1 && relay_channel !== prev) begin
        check(8'(relay_channel), exp);
        if (exp == 8'h05) check(8'(cnt), 8'h05);
        exp++;
        prev = relay_channel;
        cnt = 0;
      end
    end
    check(8'({relay_close, relay_channel}), 8'h03);
    check(exp, 8'h06);
  endtask : t_single

  task automatic t_repeat;
    logic [6:0] held;
    k(scan_pkg::KEY_REPEAT);
    settle;
    check(8'({lamps.one_pass, lamps.repeat_pass}), 8'h01);
    k(scan_pkg::KEY_START_HALT);
    while (relay_channel !== 7'h05) begin
      @(posedge clk);
      #1;
    end
    while (relay_channel === 7'h05) begin
      @(posedge clk);
      #1;
    end
    check(8'({lamps.run, relay_channel}), 8'h83);
    // Halt away from the begin channel so resume and reset are told apart
    while (relay_channel !== 7'h04) begin
      @(posedge clk);
      #1;
    end
    k(scan_pkg::KEY_START_HALT);
    settle;
    held = relay_channel;
    repeat (12) @(posedge clk);
    #1;
    check(8'({lamps.run, relay_close, relay_channel[5:0]}), 8'({2'b01, held[5:0]}));
    k(scan_pkg::KEY_START_HALT);
    @(posedge clk);
    #1;
    check(8'({lamps.run, relay_channel}), 8'({1'b1, held}));
    k(scan_pkg::KEY_RESET);
    settle;
    check(8'({lamps.run, relay_close, relay_channel[5:0]}), 8'h03);
    k(scan_pkg::KEY_START_HALT);
    @(posedge clk);
    #1;
    check(8'({lamps.run, relay_channel}), 8'h83);
    k(scan_pkg::KEY_RESET);
  endtask : t_repeat

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Watchdog: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_sim;
    end
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    rst_b = 1'b0;
    units_chained = 3'h1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_setup;
    t_single;
    t_repeat;
    settle;
    end_sim;
  end
endmodule : relay_scan_sequencer_tb_top

//--- scan_pkg.sv
/*
  Package for the relay scan sequencer: key codes, modes, limits and timing constants.
  Assumes a 10 MHz system clock and a keypad decoder that delivers one-cycle key events.
*/
package scan_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int unsigned MSG_TIME_MS     = 500;
  localparam int unsigned MSG_CYCLES      = (CLK_HZ / MS_PER_S) * MSG_TIME_MS;
  localparam int unsigned MAX_CHANNELS    = 100;
  localparam int unsigned UNIT_CHANNELS   = 20;
  localparam int unsigned MAX_UNITS       = 5;
  localparam int unsigned DWELL_DIGITS    = 6;
  localparam int unsigned CHAN_DIGITS     = 2;
  localparam int unsigned POLE_SETTING    = 6;
  localparam logic [7:0]  RESET_BEGIN     = 8'h01;
  localparam logic [7:0]  RESET_END       = 8'h01;
  localparam logic [23:0] RESET_DWELL     = 24'h001000;
  localparam logic [2:0]  RESET_POLES     = 3'h2;

  typedef enum logic [3:0] {
    KEY_DIGIT,
    KEY_BEGIN,
    KEY_END,
    KEY_DWELL,
    KEY_ENTER,
    KEY_CHANNEL,
    KEY_RESET,
    KEY_START_HALT,
    KEY_ONE_PASS,
    KEY_REPEAT,
    KEY_PROGRAM
  } key_e;

  typedef struct packed {
    logic       valid;
    key_e       code;
    logic [3:0] digit;
  } key_s;

  typedef struct packed {
    logic run;
    logic channel_view;
    logic one_pass;
    logic repeat_pass;
    logic no_channel;
  } lamps_s;

endpackage : scan_pkg
